// File: amc_defs.svh
// Offsets, field positions, reset values and zero-run counts for the control bank
`ifndef AMC_DEFS_SVH
`define AMC_DEFS_SVH

// ******************************************************
// Register offsets
// ******************************************************
`define AMC_OFS_MUTE_CTRL      8'h50
`define AMC_OFS_ZERO_RUN_TIME  8'h51
`define AMC_OFS_LOOP_BW        8'h53
`define AMC_OFS_ANALOG_GAIN    8'h54
`define AMC_OFS_BIQUAD_WR      8'h5C
`define AMC_OFS_MODULATOR      8'h5D
`define AMC_OFS_PIN_DIR        8'h60
`define AMC_OFS_PIN_FUNC       8'h61
`define AMC_OFS_BYPASS         8'h66
`define AMC_OFS_MUTE_STATE     8'h69

// ******************************************************
// Reset values
// ******************************************************
`define AMC_RST_MUTE_CTRL      3'h7
`define AMC_RST_ZERO_RUN_LEN   3'h0
`define AMC_RST_LOOP_BW        2'h0
`define AMC_RST_ANALOG_GAIN    5'h00
`define AMC_RST_MODULATOR      8'hF8
`define AMC_RST_PIN_FUNC       5'h00
`define AMC_RST_BYPASS         4'h0

// ******************************************************
// Field positions
// ******************************************************
`define AMC_MUTE_EN_LEFT       0
`define AMC_MUTE_EN_RIGHT      1
`define AMC_MUTE_JOINT         2
`define AMC_LEFT_LEN_LSB       4
`define AMC_RIGHT_LEN_LSB      0
`define AMC_LOOP_BW_LSB        5
`define AMC_BYP_EQ             0
`define AMC_BYP_DRC            1
`define AMC_BYP_FIR            2
`define AMC_BYP_UNIQUE_COEF    3

// ******************************************************
// Zero-run lengths at the reference sample rate
// ******************************************************
`define AMC_FS_KHZ             96
`define AMC_ZR_T0_US           11500
`define AMC_ZR_T1_US           53000
`define AMC_ZR_T2_US           106500
`define AMC_ZR_T3_US           266500
`define AMC_ZR_T4_US           535000
`define AMC_ZR_T5_US           1065000
`define AMC_ZR_T6_US           2665000
`define AMC_ZR_T7_US           5330000
`define AMC_ZR_CNT(t)          (20'((t) * `AMC_FS_KHZ / 1000))

`endif

// File: amc_host_model.sv
// Host model driving the register strobe port
`timescale 1ns/100ps
`default_nettype none

module amc_host_model (
  // Clock
  input  wire logic       core_clk,
  // Register port
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // ****************************************
  // Access tasks
  // ****************************************
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // Released lines show the inverse so a stale value never looks live
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(posedge core_clk);
    d = reg_rdata;
  endtask : rd
endmodule : amc_host_model

`default_nettype wire

// File: amc_misc_regs.sv
// Miscellaneous amplifier control registers, auto-mute timing and flag pin
`include "amc_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module amc_misc_regs #(
  parameter int unsigned             SAMPLE_W = 24,
  parameter logic [7:0][19:0]        ZR_CNT   = {`AMC_ZR_CNT(`AMC_ZR_T7_US),
                                                 `AMC_ZR_CNT(`AMC_ZR_T6_US),
                                                 `AMC_ZR_CNT(`AMC_ZR_T5_US),
                                                 `AMC_ZR_CNT(`AMC_ZR_T4_US),
                                                 `AMC_ZR_CNT(`AMC_ZR_T3_US),
                                                 `AMC_ZR_CNT(`AMC_ZR_T2_US),
                                                 `AMC_ZR_CNT(`AMC_ZR_T1_US),
                                                 `AMC_ZR_CNT(`AMC_ZR_T0_US)}
) (
  // Clock, reset, enable
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire logic                  core_ce,
  // Register port from the serial control front end
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  output var  logic [7:0]            reg_rdata,
  // Audio samples
  input  wire logic                  sample_valid,
  input  wire logic [SAMPLE_W-1:0]   left_sample,
  input  wire logic [SAMPLE_W-1:0]   right_sample,
  // Device status feeding the flag pin
  input  wire logic                  clk_invalid,
  input  wire logic                  fault_out_n,
  // Flag pin
  input  wire logic                  flag_pin_in,
  output var  logic                  flag_pin_out,
  output var  logic                  flag_pin_oe,
  output var  logic                  flag_pin_level,
  // Controls to the analog and processing blocks
  output var  logic [1:0]            loop_bandwidth_sel,
  output var  logic [4:0]            output_attenuation,
  output var  logic                  first_coefficient_flag,
  output var  amc_pkg::amc_mod_ctrl_s mod_ctrl,
  output var  amc_pkg::amc_dsp_ctrl_s dsp_ctrl,
  output var  logic                  left_muted_status,
  output var  logic                  right_muted_status
);

  // ******************************************************
  // Helpers
  // ******************************************************
  // One table serves both channels, so both decode identically
  function automatic logic [19:0] zr_limit(input logic [2:0] code);
    zr_limit = ZR_CNT[code];
  endfunction : zr_limit

  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = reg_wr && (reg_addr == ofs);
  endfunction : wr_hit

  // Count saturates at the limit so a long silence cannot wrap back to unmuted
  function automatic logic [19:0] zr_next(input logic [19:0] cnt,
                                          input logic [2:0]  code,
                                          input logic        zero);
    if (!zero) begin
      zr_next = 20'h00000;
    end else if (cnt >= zr_limit(code)) begin
      zr_next = cnt;
    end else begin
      zr_next = cnt + 20'h00001;
    end
  endfunction : zr_next

  // ******************************************************
  // Register file
  // ******************************************************
  logic [2:0]             mute_ctrl_q, mute_ctrl_d;
  logic [2:0]             left_zero_run_len_q, left_zero_run_len_d;
  logic [2:0]             right_zero_run_len_q, right_zero_run_len_d;
  logic [1:0]             loop_bw_q, loop_bw_d;
  logic [4:0]             gain_q, gain_d;
  logic                   first_coef_q, first_coef_d;
  amc_pkg::amc_mod_ctrl_s mod_q, mod_d;
  logic                   pin_oe_q, pin_oe_d;
  logic [4:0]             pin_func_q, pin_func_d;
  amc_pkg::amc_dsp_ctrl_s bypass_q, bypass_d;
  logic [7:0]             rdata_q, rdata_d;
  logic                   left_mute_q, right_mute_q;

  always_comb begin
    mute_ctrl_d          = mute_ctrl_q;
    left_zero_run_len_d  = left_zero_run_len_q;
    right_zero_run_len_d = right_zero_run_len_q;
    loop_bw_d            = loop_bw_q;
    gain_d               = gain_q;
    first_coef_d         = first_coef_q;
    mod_d                = mod_q;
    pin_oe_d             = pin_oe_q;
    pin_func_d           = pin_func_q;
    bypass_d             = bypass_q;
    rdata_d              = rdata_q;
    if (wr_hit(`AMC_OFS_MUTE_CTRL)) begin
      mute_ctrl_d = reg_wdata[2:0];
    end
    if (wr_hit(`AMC_OFS_ZERO_RUN_TIME)) begin
      left_zero_run_len_d  = reg_wdata[`AMC_LEFT_LEN_LSB +: 3];
      right_zero_run_len_d = reg_wdata[`AMC_RIGHT_LEN_LSB +: 3];
    end
    if (wr_hit(`AMC_OFS_LOOP_BW)) begin
      loop_bw_d = reg_wdata[`AMC_LOOP_BW_LSB +: 2];
    end
    if (wr_hit(`AMC_OFS_ANALOG_GAIN)) begin
      gain_d = reg_wdata[4:0];
    end
    if (wr_hit(`AMC_OFS_BIQUAD_WR)) begin
      first_coef_d = reg_wdata[0];
    end
    if (wr_hit(`AMC_OFS_MODULATOR)) begin
      mod_d = amc_pkg::amc_mod_ctrl_s'(reg_wdata);
    end
    if (wr_hit(`AMC_OFS_PIN_DIR)) begin
      pin_oe_d = reg_wdata[0];
    end
    if (wr_hit(`AMC_OFS_PIN_FUNC)) begin
      pin_func_d = reg_wdata[4:0];
    end
    if (wr_hit(`AMC_OFS_BYPASS)) begin
      bypass_d = amc_pkg::amc_dsp_ctrl_s'(reg_wdata[3:0]);
    end
    // Reserved bits read back as zero; unmapped offsets read zero
    if (reg_rd) begin
      case (reg_addr)
        `AMC_OFS_MUTE_CTRL:     rdata_d = {5'h00, mute_ctrl_q};
        `AMC_OFS_ZERO_RUN_TIME: rdata_d = {1'b0, left_zero_run_len_q,
                                           1'b0, right_zero_run_len_q};
        `AMC_OFS_LOOP_BW:       rdata_d = {1'b0, loop_bw_q, 5'h00};
        `AMC_OFS_ANALOG_GAIN:   rdata_d = {3'h0, gain_q};
        `AMC_OFS_BIQUAD_WR:     rdata_d = {7'h00, first_coef_q};
        `AMC_OFS_MODULATOR:     rdata_d = mod_q;
        `AMC_OFS_PIN_DIR:       rdata_d = {7'h00, pin_oe_q};
        `AMC_OFS_PIN_FUNC:      rdata_d = {3'h0, pin_func_q};
        `AMC_OFS_BYPASS:        rdata_d = {4'h0, bypass_q};
        `AMC_OFS_MUTE_STATE:    rdata_d = {6'h00, right_mute_q, left_mute_q};
        default:                rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      mute_ctrl_q          <= `AMC_RST_MUTE_CTRL;
      left_zero_run_len_q  <= `AMC_RST_ZERO_RUN_LEN;
      right_zero_run_len_q <= `AMC_RST_ZERO_RUN_LEN;
      loop_bw_q            <= `AMC_RST_LOOP_BW;
      gain_q               <= `AMC_RST_ANALOG_GAIN;
      first_coef_q         <= 1'b0;
      mod_q                <= `AMC_RST_MODULATOR;
      pin_oe_q             <= 1'b0;
      pin_func_q           <= `AMC_RST_PIN_FUNC;
      bypass_q             <= `AMC_RST_BYPASS;
      rdata_q              <= 8'h00;
    end else if (core_ce) begin
      mute_ctrl_q          <= mute_ctrl_d;
      left_zero_run_len_q  <= left_zero_run_len_d;
      right_zero_run_len_q <= right_zero_run_len_d;
      loop_bw_q            <= loop_bw_d;
      gain_q               <= gain_d;
      first_coef_q         <= first_coef_d;
      mod_q                <= mod_d;
      pin_oe_q             <= pin_oe_d;
      pin_func_q           <= pin_func_d;
      bypass_q             <= bypass_d;
      rdata_q              <= rdata_d;
    end
  end

  // ******************************************************
  // Zero-run counters and auto-mute
  // ******************************************************
  logic [19:0] left_cnt_q, left_cnt_d;
  logic [19:0] right_cnt_q, right_cnt_d;
  logic        left_mute_d, right_mute_d;
  logic        left_ready, right_ready;

  always_comb begin
    left_cnt_d  = left_cnt_q;
    right_cnt_d = right_cnt_q;
    if (sample_valid) begin
      left_cnt_d  = zr_next(left_cnt_q, left_zero_run_len_q, left_sample == '0);
      right_cnt_d = zr_next(right_cnt_q, right_zero_run_len_q, right_sample == '0);
    end
    left_ready  = mute_ctrl_q[`AMC_MUTE_EN_LEFT] &&
                  (left_cnt_d >= zr_limit(left_zero_run_len_q));
    right_ready = mute_ctrl_q[`AMC_MUTE_EN_RIGHT] &&
                  (right_cnt_d >= zr_limit(right_zero_run_len_q));
    if (mute_ctrl_q[`AMC_MUTE_JOINT]) begin
      left_mute_d  = left_ready && right_ready;
      right_mute_d = left_ready && right_ready;
    end else begin
      left_mute_d  = left_ready;
      right_mute_d = right_ready;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      left_cnt_q   <= 20'h00000;
      right_cnt_q  <= 20'h00000;
      left_mute_q  <= 1'b0;
      right_mute_q <= 1'b0;
    end else if (core_ce) begin
      left_cnt_q   <= left_cnt_d;
      right_cnt_q  <= right_cnt_d;
      left_mute_q  <= left_mute_d;
      right_mute_q <= right_mute_d;
    end
  end

  // ******************************************************
  // Flag pin
  // ******************************************************
  // Pin input is asynchronous: two flops before anything reads it
  logic pin_meta_q, pin_sync_q;
  logic pin_out_q, pin_out_d;

  always_comb begin
    case (pin_func_q)
      amc_pkg::AMC_PIN_LOW:        pin_out_d = 1'b0;
      amc_pkg::AMC_PIN_MUTE_BOTH:  pin_out_d = left_mute_q && right_mute_q;
      amc_pkg::AMC_PIN_MUTE_LEFT:  pin_out_d = left_mute_q;
      amc_pkg::AMC_PIN_MUTE_RIGHT: pin_out_d = right_mute_q;
      amc_pkg::AMC_PIN_CLK_BAD:    pin_out_d = clk_invalid;
      amc_pkg::AMC_PIN_FAULT:      pin_out_d = fault_out_n;
      // Reserved codes hold the pin low
      default:                     pin_out_d = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_out_q  <= 1'b0;
    end else if (core_ce) begin
      pin_meta_q <= flag_pin_in;
      pin_sync_q <= pin_meta_q;
      pin_out_q  <= pin_out_d;
    end
  end

  // ******************************************************
  // Outputs
  // ******************************************************
  // drive only when enabled
  assign flag_pin_oe            = pin_oe_q;
  assign flag_pin_out           = pin_out_q;
  assign flag_pin_level         = pin_sync_q;
  assign reg_rdata              = rdata_q;
  assign loop_bandwidth_sel     = loop_bw_q;
  assign output_attenuation     = gain_q;
  assign first_coefficient_flag = first_coef_q;
  assign mod_ctrl               = mod_q;
  assign dsp_ctrl               = bypass_q;
  assign left_muted_status      = left_mute_q;
  assign right_muted_status     = right_mute_q;

endmodule : amc_misc_regs

`default_nettype wire

// File: amc_misc_regs_bench.sv
// Self-checking bench for the control bank
`timescale 1ns/100ps
`default_nettype none

module amc_misc_regs_bench;
  logic                   core_clk, reset, core_ce, sample_valid, clk_invalid, fault_out_n;
  logic                   pin_drv, reg_wr, reg_rd, flag_pin_out, flag_pin_oe, flag_pin_level;
  logic                   first_coefficient_flag, left_muted_status, right_muted_status;
  logic [23:0]            left_sample, right_sample;
  logic [7:0]             reg_addr, reg_wdata, reg_rdata, rd_v, v;
  logic [3:0]             n;
  logic [1:0]             loop_bandwidth_sel;
  logic [4:0]             output_attenuation;
  amc_pkg::amc_mod_ctrl_s mod_ctrl;
  amc_pkg::amc_dsp_ctrl_s dsp_ctrl;
  wire logic              flag_wire;
  int                     failures, checks_done, cycles;
  localparam logic [7:0] OFS [11] = '{8'h50, 8'h51, 8'h53, 8'h54, 8'h5C, 8'h5D, 8'h60,
                                      8'h61, 8'h66, 8'h69, 8'h52};
  localparam logic [7:0] RST [11] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'hF8, 8'h00,
                                      8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] MSK [11] = '{8'h07, 8'h77, 8'h60, 8'h1F, 8'h01, 8'hFF, 8'h01,
                                      8'h1F, 8'h0F, 8'h00, 8'h00};

  // ****************************************
  // Harness
  // ****************************************
  // Pin level resolves from the device enable and the board driver
  assign flag_wire = flag_pin_oe ? flag_pin_out : pin_drv;

  amc_host_model host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // Short limits: code k needs k+1 zero samples
  amc_misc_regs #(.SAMPLE_W(24), .ZR_CNT({20'h8, 20'h7, 20'h6, 20'h5, 20'h4, 20'h3, 20'h2,
    20'h1})) dut (.core_clk(core_clk), .reset(reset), .core_ce(core_ce), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .left_sample(left_sample), .right_sample(right_sample),
    .clk_invalid(clk_invalid), .fault_out_n(fault_out_n), .flag_pin_in(flag_wire),
    .flag_pin_out(flag_pin_out), .flag_pin_oe(flag_pin_oe), .flag_pin_level(flag_pin_level),
    .loop_bandwidth_sel(loop_bandwidth_sel), .output_attenuation(output_attenuation),
    .first_coefficient_flag(first_coefficient_flag), .mod_ctrl(mod_ctrl),
    .dsp_ctrl(dsp_ctrl), .left_muted_status(left_muted_status),
    .right_muted_status(right_muted_status));

  always #5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      stop_test();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rd_v);
    check(rd_v, exp);
  endtask : rdchk

  task automatic samp(input int k, input logic [23:0] l, input logic [23:0] r);
    repeat (k) begin
      @(posedge core_clk);
      sample_valid <= 1'b1;
      left_sample  <= l;
      right_sample <= r;
      @(posedge core_clk);
      sample_valid <= 1'b0;
    end
    @(posedge core_clk);
  endtask : samp

  // Pin output lags the function field by one cycle
  task automatic pin(input logic [7:0] code, input logic exp);
    host.wr(8'h61, code);
    repeat (2) @(posedge core_clk);
    check(flag_pin_out, exp);
  endtask : pin

  task automatic stop_test();
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {core_clk, sample_valid, pin_drv, left_sample, right_sample} = '0;
    {reset, core_ce, clk_invalid, fault_out_n} = 4'hF;
    {failures, checks_done, cycles} = '0;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    for (int i = 0; i < 11; i++) rdchk(OFS[i], RST[i]);
    check(mod_ctrl, 8'hF8);
    for (int i = 0; i < 11; i++) begin
      host.wr(OFS[i], 8'hFF);
      rdchk(OFS[i], MSK[i]);
    end
    check(first_coefficient_flag, 1'b1);
    for (int i = 0; i < 16; i++) begin
      n = i[3:0];
      v = {n, ~n};
      host.wr(8'h53, v);
      host.wr(8'h54, v);
      host.wr(8'h5D, v);
      host.wr(8'h66, v);
      @(posedge core_clk);
      check(loop_bandwidth_sel, n[2:1]);
      check(output_attenuation, v[4:0]);
      check(mod_ctrl, v);
      check(dsp_ctrl, {4'h0, ~n});
    end
    // A write while the enable is low must be ignored
    core_ce <= 1'b0;
    host.wr(8'h54, 8'h05);
    core_ce <= 1'b1;
    @(posedge core_clk);
    check(output_attenuation, 8'h10);
    host.wr(8'h60, 8'h00);
    pin_drv <= 1'b1;
    repeat (3) @(posedge core_clk);
    check(flag_pin_level, 1'b1);
    host.wr(8'h60, 8'h01);
    @(posedge core_clk);
    check(flag_pin_oe, 1'b1);
    pin(8'h06, 1'b1);
    pin(8'h0B, 1'b1);
    pin(8'h00, 1'b0);
    pin(8'h07, 1'b0);
    pin(8'h03, 1'b0);
    clk_invalid <= 1'b0;
    fault_out_n <= 1'b0;
    pin(8'h06, 1'b0);
    pin(8'h0B, 1'b0);
    host.wr(8'h50, 8'h03);
    samp(7, 24'h0, 24'h0);
    check({left_muted_status, right_muted_status}, 2'b00);
    samp(1, 24'h0, 24'h0);
    check(left_muted_status, 1'b1);
    check(right_muted_status, 1'b1);
    rdchk(8'h69, 8'h03);
    pin(8'h03, 1'b1);
    pin(8'h04, 1'b1);
    samp(1, 24'h1, 24'h0);
    check(left_muted_status, 1'b0);
    check(right_muted_status, 1'b1);
    pin(8'h05, 1'b1);
    host.wr(8'h51, 8'h20);
    host.wr(8'h50, 8'h07);
    samp(2, 24'h0, 24'h0);
    check({left_muted_status, right_muted_status}, 2'b00);
    samp(1, 24'h0, 24'h0);
    rdchk(8'h69, 8'h03);
    stop_test();
  end
endmodule : amc_misc_regs_bench

`default_nettype wire

// File: amc_misc_regs_props.sv
// Checker for the control bank ports
`timescale 1ns/100ps
`default_nettype none

module amc_misc_regs_props #(
  parameter int unsigned SAMPLE_W = 24
) (
  // Clock and reset
  input wire logic                   core_clk,
  input wire logic                   reset,
  input wire logic                   core_ce,
  // Register port
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [7:0]             reg_addr,
  input wire logic [7:0]             reg_wdata,
  input wire logic [7:0]             reg_rdata,
  // Samples
  input wire logic                   sample_valid,
  input wire logic [SAMPLE_W-1:0]    left_sample,
  input wire logic [SAMPLE_W-1:0]    right_sample,
  // Controls and status
  input wire logic                   flag_pin_oe,
  input wire logic [1:0]             loop_bandwidth_sel,
  input wire logic [4:0]             output_attenuation,
  input wire amc_pkg::amc_mod_ctrl_s mod_ctrl,
  input wire amc_pkg::amc_dsp_ctrl_s dsp_ctrl,
  input wire logic                   left_muted_status,
  input wire logic                   right_muted_status
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // A write taken at one offset
  sequence s_wr(logic [7:0] a);
    reg_wr && core_ce && reg_addr == a;
  endsequence

  chk_pin_dir: assert property (s_wr(8'h60) |=> flag_pin_oe == $past(reg_wdata[0]))
    else $error("flag pin direction not taken from write");
  chk_bw_write: assert property (s_wr(8'h53) |=> loop_bandwidth_sel == $past(reg_wdata[6:5]))
    else $error("loop bandwidth not taken from write");
  chk_gain_write: assert property (s_wr(8'h54) |=> output_attenuation == $past(reg_wdata[4:0]))
    else $error("attenuation not taken from write");
  chk_mod_write: assert property (s_wr(8'h5D) |=> mod_ctrl == $past(reg_wdata))
    else $error("modulator control not taken from write");
  chk_bypass_write: assert property (s_wr(8'h66) |=> dsp_ctrl == $past(reg_wdata[3:0]))
    else $error("bypass control not taken from write");
  // An enable or length write may also complete a run, two cycles later
  chk_left_rise: assert property ($rose(left_muted_status)
    |-> $past(sample_valid && core_ce && left_sample == '0)
        || $past(reg_wr && core_ce && (reg_addr == 8'h50 || reg_addr == 8'h51), 2))
    else $error("left mute rose without a zero sample");
  chk_left_clear: assert property (sample_valid && core_ce && left_sample != '0
    |=> !left_muted_status)
    else $error("left mute held after nonzero sample");
  chk_right_clear: assert property (sample_valid && core_ce && right_sample != '0
    |=> !right_muted_status)
    else $error("right mute held after nonzero sample");
  chk_status_read: assert property (reg_rd && core_ce && reg_addr == 8'h69 |=> reg_rdata
    == {6'h00, $past(right_muted_status), $past(left_muted_status)})
    else $error("mute status readback wrong");
endmodule : amc_misc_regs_props

bind amc_misc_regs amc_misc_regs_props #(.SAMPLE_W(SAMPLE_W)) u_props (
  .core_clk(core_clk), .reset(reset), .core_ce(core_ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .sample_valid(sample_valid), .left_sample(left_sample), .right_sample(right_sample),
  .flag_pin_oe(flag_pin_oe), .loop_bandwidth_sel(loop_bandwidth_sel),
  .output_attenuation(output_attenuation), .mod_ctrl(mod_ctrl), .dsp_ctrl(dsp_ctrl),
  .left_muted_status(left_muted_status), .right_muted_status(right_muted_status));

`default_nettype wire

// File: amc_pkg.sv
// Types shared by the control bank
package amc_pkg;

  // Modulator clock, dither and element matching
  typedef struct packed {
    logic       clk_sel;
    logic [1:0] dither_en;
    logic [2:0] dither_level;
    logic [1:0] element_matching_sel;
  } amc_mod_ctrl_s;

  // Processing chain switches
  typedef struct packed {
    logic unique_coef;
    logic bypass_fir;
    logic bypass_drc;
    logic bypass_eq;
  } amc_dsp_ctrl_s;

  // Flag pin functions
  typedef enum logic [4:0] {
    AMC_PIN_LOW        = 5'h00,
    AMC_PIN_MUTE_BOTH  = 5'h03,
    AMC_PIN_MUTE_LEFT  = 5'h04,
    AMC_PIN_MUTE_RIGHT = 5'h05,
    AMC_PIN_CLK_BAD    = 5'h06,
    AMC_PIN_FAULT      = 5'h0B
  } amc_pin_func_e;

endpackage : amc_pkg
